// File: rtl/cwc_map.svh
// Purpose: Register map, field positions and counts for the week counter
// Assumes: Avalon byte addresses, one 32-bit word per register
// Notes:   Definitions only
// Behaviour
// - Reset clears controls; enables gate clock and counting
// - Clock enable low holds prescaler at zero
// - Three ticks after enable, load settings, count
// - Each counter wrap increments the next one
// - Full wrap clears all, pulses overflow one tick
// - Count restart: load after two, run three later
// - Tick period 0111 per second, 1000 per minute
// - Reset selects subclock as count clock
// - Clock enable cycle reloads and restarts counting
// - Count enable cycle reloads, keeps prescaler value
// - Seconds and minutes run 0 to 59
// - Hours run 0 to 23
// - Days run 0 to 6
// - Weeks are 12 bits, 0 to 4095
`ifndef CWC_MAP_SVH
`define CWC_MAP_SVH
// Register byte offsets
`define CWC_A_CTRL0     8'h00
`define CWC_A_CTRL1     8'h04
`define CWC_A_SUBSEC    8'h08
`define CWC_A_SEC       8'h0c
`define CWC_A_MIN       8'h10
`define CWC_A_HOUR      8'h14
`define CWC_A_DAY       8'h18
`define CWC_A_WEEK      8'h1c
`define CWC_A_SET_SEC   8'h20
`define CWC_A_SET_MIN   8'h24
`define CWC_A_SET_HOUR  8'h28
`define CWC_A_SET_DAY   8'h2c
`define CWC_A_SET_WEEK  8'h30
// Control fields
`define CWC_B_CLK_EN    0
`define CWC_B_CLK_SEL   1
`define CWC_F_TP_HI     7
`define CWC_F_TP_LO     4
`define CWC_B_CNT_EN    0
`define CWC_B_RUNNING   1
// Wrap limits
`define CWC_SEC_MAX     6'h3b
`define CWC_MIN_MAX     6'h3b
`define CWC_HOUR_MAX    5'h17
`define CWC_DAY_MAX     3'h6
`define CWC_WEEK_MAX    12'hfff
`define CWC_SUB_MAX     15'h7fff
// Start-up waits in count-clock ticks
`define CWC_ARM_WAIT    3'h3
`define CWC_PRE_WAIT    3'h2
`define CWC_POST_WAIT   3'h3
// Tick period codes
`define CWC_TP_SEC      4'h7
`define CWC_TP_MIN      4'h8
`define CWC_TP_HOUR     4'h9
`define CWC_TP_DAY      4'ha
`endif

// File: rtl/cwc_pkg.sv
// Purpose: Shared types of the week counter
// Assumes: Constants come from cwc_map.svh
// Notes:   Sequencer states only
`default_nettype none
package cwc_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    S_OFF, S_ARM, S_PRE, S_POST, S_RUN, S_HALT
  } cwc_state_e;
endpackage
`default_nettype wire

// File: rtl/cwc_if.sv
// Purpose: Control and status between register file and counter core
// Assumes: Single clock domain
// Notes:   No clocking block
`default_nettype none
interface cwc_if;
  logic        clock_enable;       // Counter clock runs
  logic        count_clock_select; // 1 selects prescaler clock
  logic        count_enable;       // Counting allowed
  logic [3:0]  tick_period_field;  // Periodic tick rate
  logic [5:0]  set_sec;            // Setting registers
  logic [5:0]  set_min;
  logic [4:0]  set_hour;
  logic [2:0]  set_day;
  logic [11:0] set_week;
  logic        counter_running_flag; // Core counting
  logic [14:0] subsecond_prescaler;
  logic [5:0]  sec;                // Count registers
  logic [5:0]  min;
  logic [4:0]  hour;
  logic [2:0]  day;
  logic [11:0] week;
  modport regs (output clock_enable, count_clock_select, count_enable, tick_period_field,
                set_sec, set_min, set_hour, set_day, set_week,
                input counter_running_flag, subsecond_prescaler, sec, min, hour, day, week);
  modport core (input clock_enable, count_clock_select, count_enable, tick_period_field,
                set_sec, set_min, set_hour, set_day, set_week,
                output counter_running_flag, subsecond_prescaler, sec, min, hour, day, week);
endinterface
`default_nettype wire

// File: rtl/cwc_clk_sel.sv
// Purpose: Turns the two external count clocks into one-cycle tick enables
// Assumes: Both count clocks far slower than clk
// Notes:   Tick is registered; one per rising edge of the selected clock
`default_nettype none
module cwc_clk_sel (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Pins
  input  wire logic subclock,
  input  wire logic prescaler_clock,
  // Control
  input  wire logic select,
  // Tick out
  output var  logic tick
);
  logic [1:0] pin;       // Raw pins
  logic [1:0] sync1;     // First stage, read by sync2 only
  logic [1:0] sync2;     // Second stage
  logic [1:0] sync3;     // Edge history
  logic [1:0] rise;      // Rising edges
  logic       next_tick; // Next tick value

  assign pin = {prescaler_clock, subclock};

  // Synchroniser and edge detect per clock
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= pin[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
      assign rise[g] = sync2[g] & ~sync3[g];
    end
  endgenerate

  // Select source; switching live may drop or add one tick
  always_comb begin
    next_tick = select ? rise[1] : rise[0];
  end

  // Register tick
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// File: rtl/cwc_regs.sv
// Purpose: Avalon-MM slave holding control and setting registers
// Assumes: One request at a time, master holds it until waitrequest low
// Notes:   Answer two edges after request; unmapped reads give zero
`include "cwc_map.svh"
`default_nettype none
module cwc_regs
  import cwc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Core side
  cwc_if.regs              cif
);
  logic        ack;       // Answer phase
  logic        next_ack;
  logic [31:0] next_rd;   // Read data
  logic        next_ce, next_sel, next_cen;
  logic [3:0]  next_tp;
  logic [5:0]  next_ssec, next_smin;
  logic [4:0]  next_shour;
  logic [2:0]  next_sday;
  logic [11:0] next_sweek;
  logic        wr;        // Write takes effect now

  // Hold master until ack cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr = avs_write & ack;

  // Next register values
  always_comb begin
    next_ack   = (avs_read | avs_write) & ~ack;
    next_rd    = avs_readdata;
    next_ce    = cif.clock_enable;
    next_sel   = cif.count_clock_select;
    next_cen   = cif.count_enable;
    next_tp    = cif.tick_period_field;
    next_ssec  = cif.set_sec;
    next_smin  = cif.set_min;
    next_shour = cif.set_hour;
    next_sday  = cif.set_day;
    next_sweek = cif.set_week;
    // Read data captured in the request cycle
    if (avs_read && !ack) begin
      next_rd = 32'h0;
      case (avs_address)
        `CWC_A_CTRL0: begin
          next_rd[`CWC_B_CLK_EN]             = cif.clock_enable;
          next_rd[`CWC_B_CLK_SEL]            = cif.count_clock_select;
          next_rd[`CWC_F_TP_HI:`CWC_F_TP_LO] = cif.tick_period_field;
        end
        `CWC_A_CTRL1: begin
          next_rd[`CWC_B_CNT_EN]  = cif.count_enable;
          next_rd[`CWC_B_RUNNING] = cif.counter_running_flag;
        end
        `CWC_A_SUBSEC:   next_rd[14:0] = cif.subsecond_prescaler;
        `CWC_A_SEC:      next_rd[5:0]  = cif.sec;
        `CWC_A_MIN:      next_rd[5:0]  = cif.min;
        `CWC_A_HOUR:     next_rd[4:0]  = cif.hour;
        `CWC_A_DAY:      next_rd[2:0]  = cif.day;
        `CWC_A_WEEK:     next_rd[11:0] = cif.week;
        `CWC_A_SET_SEC:  next_rd[5:0]  = cif.set_sec;
        `CWC_A_SET_MIN:  next_rd[5:0]  = cif.set_min;
        `CWC_A_SET_HOUR: next_rd[4:0]  = cif.set_hour;
        `CWC_A_SET_DAY:  next_rd[2:0]  = cif.set_day;
        `CWC_A_SET_WEEK: next_rd[11:0] = cif.set_week;
        default:         next_rd = 32'h0; // Unmapped
      endcase
    end
    // Writes; status and unmapped offsets ignore them
    if (wr) begin
      case (avs_address)
        `CWC_A_CTRL0: begin
          next_ce  = avs_writedata[`CWC_B_CLK_EN];
          next_sel = avs_writedata[`CWC_B_CLK_SEL];
          next_tp  = avs_writedata[`CWC_F_TP_HI:`CWC_F_TP_LO];
        end
        `CWC_A_CTRL1:    next_cen   = avs_writedata[`CWC_B_CNT_EN];
        `CWC_A_SET_SEC:  next_ssec  = avs_writedata[5:0];
        `CWC_A_SET_MIN:  next_smin  = avs_writedata[5:0];
        `CWC_A_SET_HOUR: next_shour = avs_writedata[4:0];
        `CWC_A_SET_DAY:  next_sday  = avs_writedata[2:0];
        `CWC_A_SET_WEEK: next_sweek = avs_writedata[11:0];
        default:         next_ack   = 1'b0;
      endcase
    end
  end

  // Registers; reset clears both control words
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack                    <= 1'b0;
      avs_readdata           <= 32'h0;
      cif.clock_enable       <= 1'b0;
      cif.count_clock_select <= 1'b0;
      cif.count_enable       <= 1'b0;
      cif.tick_period_field  <= 4'h0;
      cif.set_sec            <= 6'h00;
      cif.set_min            <= 6'h00;
      cif.set_hour           <= 5'h00;
      cif.set_day            <= 3'h0;
      cif.set_week           <= 12'h000;
    end else begin
      ack                    <= next_ack;
      avs_readdata           <= next_rd;
      cif.clock_enable       <= next_ce;
      cif.count_clock_select <= next_sel;
      cif.count_enable       <= next_cen;
      cif.tick_period_field  <= next_tp;
      cif.set_sec            <= next_ssec;
      cif.set_min            <= next_smin;
      cif.set_hour           <= next_shour;
      cif.set_day            <= next_sday;
      cif.set_week           <= next_sweek;
    end
  end
endmodule
`default_nettype wire

// File: rtl/cwc_top.sv
// Purpose: Second, minute, hour, day and week counter with prescaler
// Assumes: Count clocks arrive as pins far slower than clk
// Notes:   All count logic advances only on the selected count tick
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`include "cwc_map.svh"
`default_nettype none
module cwc_top
  import cwc_pkg::*;
#(
  parameter logic [14:0] SUB_MAX = `CWC_SUB_MAX // Prescaler wrap
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Count clock pins
  input  wire logic        subclock,
  input  wire logic        prescaler_clock,
  // Interrupt requests
  output var  logic        week_overflow_irq,
  output var  logic        periodic_tick_irq
);
  cwc_if cif ();

  cwc_state_e  state;        // Sequencer
  cwc_state_e  next_state;
  logic [2:0]  wait_cnt;     // Ticks waited
  logic [2:0]  next_wait;
  logic        tick;         // Count clock enable
  logic [14:0] subsec;       // Count registers
  logic [5:0]  sec;
  logic [5:0]  min;
  logic [4:0]  hour;
  logic [2:0]  day;
  logic [11:0] week;
  logic [14:0] next_sub;
  logic [5:0]  next_sec;
  logic [5:0]  next_min;
  logic [4:0]  next_hour;
  logic [2:0]  next_day;
  logic [11:0] next_week;
  logic        next_ovf;
  logic        next_tick;
  logic        sub_wrap;     // Wrap chain
  logic        sec_wrap;
  logic        min_wrap;
  logic        hour_wrap;
  logic        day_wrap;
  logic        week_wrap;
  logic        ce;           // Short names of controls
  logic        cen;

  // Register file
  cwc_regs u_regs (
    .clk             (clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .cif             (cif.regs)
  );

  // Count tick source
  cwc_clk_sel u_clk_sel (
    .clk             (clk),
    .rstn            (rstn),
    .subclock        (subclock),
    .prescaler_clock (prescaler_clock),
    .select          (cif.count_clock_select),
    .tick            (tick)
  );

  assign ce  = cif.clock_enable;
  assign cen = cif.count_enable;

  // Status back to registers
  assign cif.counter_running_flag = (state == S_RUN);
  assign cif.subsecond_prescaler  = subsec;
  assign cif.sec                  = sec;
  assign cif.min                  = min;
  assign cif.hour                 = hour;
  assign cif.day                  = day;
  assign cif.week                 = week;

  // Tick period decode against the wrap chain
  function automatic logic period_hit(input logic [3:0] code, input logic [3:0] wraps);
    case (code)
      `CWC_TP_SEC:  period_hit = wraps[0];
      `CWC_TP_MIN:  period_hit = wraps[1];
      `CWC_TP_HOUR: period_hit = wraps[2];
      `CWC_TP_DAY:  period_hit = wraps[3];
      default:      period_hit = 1'b0;
    endcase
  endfunction

  // Overflow chain, each stage only when all below wrap
  always_comb begin
    sub_wrap  = (subsec == SUB_MAX);
    sec_wrap  = sub_wrap & (sec == `CWC_SEC_MAX);
    min_wrap  = sec_wrap & (min == `CWC_MIN_MAX);
    hour_wrap = min_wrap & (hour == `CWC_HOUR_MAX);
    day_wrap  = hour_wrap & (day == `CWC_DAY_MAX);
    week_wrap = day_wrap & (week == `CWC_WEEK_MAX);
  end

  // Sequencer and counters, next values
  always_comb begin
    next_state = state;
    next_wait  = wait_cnt;
    next_sub   = subsec;
    next_sec   = sec;
    next_min   = min;
    next_hour  = hour;
    next_day   = day;
    next_week  = week;
    // A tick ends both pulses even when a control change wins this cycle
    next_ovf   = tick ? 1'b0 : week_overflow_irq;
    next_tick  = tick ? 1'b0 : periodic_tick_irq;
    if (!ce) begin
      // Clock stopped: prescaler held at zero, counts kept
      next_state = S_OFF;
      next_wait  = 3'h0;
      next_sub   = 15'h0;
      next_ovf   = 1'b0;
      next_tick  = 1'b0;
    end else if (state == S_OFF) begin
      // Enable seen, start counting start-up ticks
      next_state = S_ARM;
      next_wait  = 3'h0;
    end else if (!cen && (state == S_RUN || state == S_PRE || state == S_POST)) begin
      // Counting stops at once so the flag drops promptly
      next_state = S_HALT;
      next_wait  = 3'h0;
    end else if (state == S_HALT && cen) begin
      next_state = S_PRE;
      next_wait  = 3'h0;
    end else if (tick) begin
      // Interrupts last exactly one count-clock cycle
      next_ovf  = 1'b0;
      next_tick = 1'b0;
      next_wait = wait_cnt + 3'h1;
      unique case (state)
        S_ARM: begin
          if (wait_cnt == `CWC_ARM_WAIT - 3'h1) begin
            // Load all settings at once
            next_sec   = cif.set_sec;
            next_min   = cif.set_min;
            next_hour  = cif.set_hour;
            next_day   = cif.set_day;
            next_week  = cif.set_week;
            next_state = cen ? S_RUN : S_HALT;
            next_wait  = 3'h0;
          end
        end
        S_PRE: begin
          if (wait_cnt == `CWC_PRE_WAIT - 3'h1) begin
            // Prescaler keeps its value here
            next_sec   = cif.set_sec;
            next_min   = cif.set_min;
            next_hour  = cif.set_hour;
            next_day   = cif.set_day;
            next_week  = cif.set_week;
            next_state = S_POST;
            next_wait  = 3'h0;
          end
        end
        S_POST: begin
          if (wait_cnt == `CWC_POST_WAIT - 3'h1) begin
            next_state = S_RUN;
            next_wait  = 3'h0;
          end
        end
        S_RUN: begin
          next_wait = 3'h0;
          // Cascade: each wrap carries into the next stage
          next_sub = sub_wrap ? 15'h0 : subsec + 15'h1;
          if (sub_wrap) begin
            next_sec = sec_wrap ? 6'h00 : sec + 6'h01;
          end
          if (sec_wrap) begin
            next_min = min_wrap ? 6'h00 : min + 6'h01;
          end
          if (min_wrap) begin
            next_hour = hour_wrap ? 5'h00 : hour + 5'h01;
          end
          if (hour_wrap) begin
            next_day = day_wrap ? 3'h0 : day + 3'h1;
          end
          if (day_wrap) begin
            next_week = week + 12'h001;
          end
          next_ovf  = week_wrap;
          next_tick = period_hit(cif.tick_period_field,
                                 {hour_wrap, min_wrap, sec_wrap, sub_wrap});
        end
        S_OFF, S_HALT: begin
          next_wait = 3'h0;
        end
      endcase
    end
  end

  // Register sequencer, counters and interrupts
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state             <= S_OFF;
      wait_cnt          <= 3'h0;
      subsec            <= 15'h0;
      sec               <= 6'h00;
      min               <= 6'h00;
      hour              <= 5'h00;
      day               <= 3'h0;
      week              <= 12'h000;
      week_overflow_irq <= 1'b0;
      periodic_tick_irq <= 1'b0;
    end else begin
      state             <= next_state;
      wait_cnt          <= next_wait;
      subsec            <= next_sub;
      sec               <= next_sec;
      min               <= next_min;
      hour              <= next_hour;
      day               <= next_day;
      week              <= next_week;
      week_overflow_irq <= next_ovf;
      periodic_tick_irq <= next_tick;
    end
  end

  // Checks
  property p_run_needs_en;
    @(posedge clk) disable iff (!rstn)
      // State leaves run one clk after a control drops
      (state == S_RUN) |-> ($past(ce) && $past(cen));
  endproperty
  a_run_needs_en: assert property (p_run_needs_en) else $error("Running without enables");

  property p_hold_sub;
    @(posedge clk) disable iff (!rstn)
      !ce ##1 !ce |-> (subsec == 15'h0) && (state == S_OFF);
  endproperty
  a_hold_sub: assert property (p_hold_sub) else $error("Prescaler not held");

  property p_arm_load;
    @(posedge clk) disable iff (!rstn)
      (state == S_ARM && tick && ce && wait_cnt == `CWC_ARM_WAIT - 3'h1)
        |=> (sec == $past(cif.set_sec)) && (week == $past(cif.set_week));
  endproperty
  a_arm_load: assert property (p_arm_load) else $error("Settings not loaded on enable");

  property p_sec_carry;
    @(posedge clk) disable iff (!rstn)
      (state == S_RUN && tick && ce && cen && sub_wrap && !sec_wrap)
        |=> (sec == $past(sec) + 6'h01) && (subsec == 15'h0);
  endproperty
  a_sec_carry: assert property (p_sec_carry) else $error("Second carry lost");

  property p_overflow;
    @(posedge clk) disable iff (!rstn)
      (state == S_RUN && tick && ce && cen && week_wrap)
        |=> week_overflow_irq && (week == 12'h000) && (sec == 6'h00) && (day == 3'h0);
  endproperty
  a_overflow: assert property (p_overflow) else $error("Overflow not raised");

  property p_pre_load;
    @(posedge clk) disable iff (!rstn)
      (state == S_PRE && tick && ce && cen && wait_cnt == `CWC_PRE_WAIT - 3'h1)
        |=> (state == S_POST) && (min == $past(cif.set_min)) && (subsec == $past(subsec));
  endproperty
  a_pre_load: assert property (p_pre_load) else $error("Restart load wrong");

  property p_tick_min;
    @(posedge clk) disable iff (!rstn)
      (state == S_RUN && tick && ce && cen && cif.tick_period_field == `CWC_TP_MIN)
        |=> (periodic_tick_irq == $past(sec_wrap));
  endproperty
  a_tick_min: assert property (p_tick_min) else $error("Minute tick wrong");

  property p_hour_wrap;
    @(posedge clk) disable iff (!rstn)
      (state == S_RUN && tick && ce && cen && hour_wrap) |=> (hour == 5'h00);
  endproperty
  a_hour_wrap: assert property (p_hour_wrap) else $error("Hour did not wrap");

  property p_irq_one_tick;
    @(posedge clk) disable iff (!rstn)
      (periodic_tick_irq && tick) |=> !periodic_tick_irq;
  endproperty
  a_irq_one_tick: assert property (p_irq_one_tick) else $error("Tick too long");

  c_overflow: cover property (@(posedge clk) disable iff (!rstn) week_overflow_irq);
  c_restart:  cover property (@(posedge clk) disable iff (!rstn) state == S_POST ##1 state == S_RUN);
  c_tick:     cover property (@(posedge clk) disable iff (!rstn) $rose(periodic_tick_irq));
endmodule
`default_nettype wire

// File: tb/cwc_top_tb.sv
// Purpose: Self-checking bench for the week counter over its Avalon port
// Assumes: SUB_MAX shortened to 3, so one second is four count ticks
// Notes:   Count ticks are 40 clk apart; irq pulses should last that long
`include "cwc_map.svh"
`default_nettype none
module cwc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CP = 40;               // Clk cycles per count tick
  logic        clk;                     // Clock and reset
  logic        rstn;
  logic [7:0]  avs_address;             // Bus request
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;                      // Last read word
  logic        subclock;                // Count clock pins
  logic        prescaler_clock;
  logic        week_overflow_irq;       // Interrupt pulses
  logic        periodic_tick_irq;
  int          err_count;
  int          cmp_count;

  cwc_top #(.SUB_MAX(15'h3)) i_cwc_top (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .subclock(subclock),
    .prescaler_clock(prescaler_clock), .week_overflow_irq(week_overflow_irq),
    .periodic_tick_irq(periodic_tick_irq));

  // Free running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Both count clocks toggle every half tick, so either select works
  initial begin
    subclock = 1'b0;
    prescaler_clock = 1'b0;
    forever begin
      repeat (CP / 2) @(posedge clk);
      subclock <= ~subclock;
      prescaler_clock <= ~prescaler_clock;
    end
  end

  task automatic give_verdict;
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus cycle; held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20) chk("waitrequest", 32'h1, 32'h0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // Bounded wait for a fresh rising pulse on one irq
  task automatic wait_irq(input bit ovf, input int lim);
    while ((ovf ? week_overflow_irq : periodic_tick_irq) === 1'b1 && lim > 0) begin
      @(posedge clk);
      lim--;
    end
    do @(posedge clk); while ((ovf ? week_overflow_irq : periodic_tick_irq) !== 1'b1 && --lim > 0);
    if (lim <= 0) chk("irq wait", 32'h0, 32'h1);
  endtask

  task automatic t_reset;
    rdchk("ctrl0", `CWC_A_CTRL0, 32'h0);
    rdchk("ctrl1", `CWC_A_CTRL1, 32'h0);
    rdchk("unmapped", 8'h3c, 32'h0);
  endtask

  // Load settings two seconds before the full wrap, then watch it happen
  task automatic t_wrap;
    int n;
    bus(1'b1, `CWC_A_SET_SEC, 32'h3a);
    bus(1'b1, `CWC_A_SET_MIN, 32'h3b);
    bus(1'b1, `CWC_A_SET_HOUR, 32'h17);
    bus(1'b1, `CWC_A_SET_DAY, 32'h6);
    bus(1'b1, `CWC_A_SET_WEEK, 32'hfff);
    bus(1'b1, `CWC_A_CTRL1, 32'h1);
    bus(1'b1, `CWC_A_CTRL0, {24'h0, `CWC_TP_SEC, 4'h1}); // Settings first
    repeat (5 * CP) @(posedge clk);
    rdchk("sec", `CWC_A_SEC, 32'h3a);
    rdchk("week", `CWC_A_WEEK, 32'hfff);
    wait_irq(1'b0, 8 * CP);
    rdchk("sec", `CWC_A_SEC, 32'h3b);
    wait_irq(1'b1, 8 * CP);
    n = 0;
    while (week_overflow_irq === 1'b1 && n < 4 * CP) begin
      @(posedge clk);
      n++;
    end
    chk("overflow width", 32'(n), 32'(CP));
    rdchk("sec", `CWC_A_SEC, 32'h0);
    rdchk("min", `CWC_A_MIN, 32'h0);
    rdchk("hour", `CWC_A_HOUR, 32'h0);
    rdchk("day", `CWC_A_DAY, 32'h0);
    rdchk("week", `CWC_A_WEEK, 32'h0);
    rdchk("sec again", `CWC_A_SEC, 32'h0);
  endtask

  // Stop counting, reload, restart through count enable
  task automatic t_restart;
    bus(1'b1, `CWC_A_CTRL1, 32'h0);
    rdchk("running", `CWC_A_CTRL1, 32'h0);
    bus(1'b1, `CWC_A_SET_SEC, 32'h0a);
    bus(1'b1, `CWC_A_SET_MIN, 32'h5);
    bus(1'b1, `CWC_A_CTRL1, 32'h1);
    repeat (3 * CP) @(posedge clk);
    rdchk("sec", `CWC_A_SEC, 32'h0a);
    repeat (4 * CP) @(posedge clk);
    rdchk("running", `CWC_A_CTRL1, 32'h3);
  endtask

  // Minute period: the tick lands on the minute rollover
  task automatic t_minute;
    bus(1'b1, `CWC_A_CTRL0, {24'h0, `CWC_TP_MIN, 4'h1}); // Masks live outside
    wait_irq(1'b0, 64 * 4 * CP);
    rdchk("sec", `CWC_A_SEC, 32'h0);
    rdchk("min", `CWC_A_MIN, 32'h6);
  endtask

  // Clock off clears the prescaler; a second reset clears the select
  task automatic t_off;
    bus(1'b1, `CWC_A_CTRL0, 32'h0); // Unused counter off
    bus(1'b1, `CWC_A_CTRL0, 32'h2); // Source changes only while off
    repeat (2 * CP) @(posedge clk);
    rdchk("subsec", `CWC_A_SUBSEC, 32'h0);
    chk("tick irq", {31'h0, periodic_tick_irq}, 32'h0);
    rdchk("ctrl0", `CWC_A_CTRL0, 32'h2);
    rstn <= 1'b0; // Prescaler source, so nothing is kept across reset
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk("ctrl0", `CWC_A_CTRL0, 32'h0);
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset; // Pending flags live outside, nothing to clear
    t_wrap;
    t_restart;
    t_minute;
    t_off;
    give_verdict;
  end

  // Watchdog well beyond the roughly 9000 cycles the tests need
  initial begin
    #(30000 * 8);
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
